// *** design/klp_params.svh ***
// register map, field positions, reset values and timing for the keypad led pwm block
`ifndef KLP_PARAMS_SVH
`define KLP_PARAMS_SVH

`define KLP_ADDR_CTRL 8'h00
`define KLP_ADDR_DIM 8'h01
`define KLP_ADDR_EXTPWM 8'h07
`define KLP_ADDR_BOOST 8'h10
`define KLP_ADDR_STATUS 8'h11

`define KLP_CTRL_ON1 0
`define KLP_CTRL_ON2 1
`define KLP_CTRL_ON3 2
`define KLP_CTRL_INTPWM 3
`define KLP_CTRL_DRVEN 4
`define KLP_CTRL_MODESW 5
`define KLP_CTRL_MASK 8'h3f
`define KLP_CTRL_RESET 8'h20

`define KLP_DIM_MASK 8'h7f
`define KLP_DIM_RESET 8'h00
`define KLP_EXT_MASK 8'h07
`define KLP_EXT_RESET 8'h00
`define KLP_BOOST_EN 0
`define KLP_BOOST_RESET 1'b0

`define KLP_CLK_NS 10
`define KLP_FRAME_US 50
`define KLP_SOFT_MS 20
`define KLP_FRAME_CYC ((`KLP_FRAME_US * 1000) / `KLP_CLK_NS)
`define KLP_SOFT_CYC ((`KLP_SOFT_MS * 1000000 + `KLP_CLK_NS - 1) / `KLP_CLK_NS)
`endif

// *** design/klp_pkg.sv ***
// types shared by the keypad led pwm block
package klp_pkg;
  typedef enum logic [2:0] {
    KLP_ST_STBY = 3'b001,
    KLP_ST_SOFT = 3'b010,
    KLP_ST_NORM = 3'b100
  } klp_boost_state_t;

  typedef struct packed {
    logic sinkOut3;
    logic sinkOut2;
    logic sinkOut1;
  } klp_sink_t;

  typedef struct packed {
    logic [2:0] balance;
    logic [2:0] bright;
    logic concurrentSlotsSel;
  } klp_dim_t;

  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } klp_reg_req_t;
endpackage

// *** design/klp_frame_timer.sv ***
// free-running frame counter with a frame-start pulse
`timescale 1ns/100ps
module klp_frame_timer #(
  parameter int FRAME_CYC = 5000,
  parameter int CW = $clog2(FRAME_CYC + 1)
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // frame position
  output logic [CW-1:0] frameCnt,
  output logic frameStart
);
  logic [CW-1:0] cnt_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (cnt_r == CW'(FRAME_CYC - 1)) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  assign frameCnt = cnt_r;
  assign frameStart = (cnt_r == '0);
endmodule // klp_frame_timer

// *** design/klp_soft_start.sv ***
// boost standby / soft start / normal sequencer
`timescale 1ns/100ps
module klp_soft_start
  import klp_pkg::*;
#(
  parameter int SOFT_CYC = 2000000,
  parameter int SW = $clog2(SOFT_CYC + 1)
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // boost run enable from the register
  input wire logic boostEn,
  // converter state
  output klp_pkg::klp_boost_state_t boostState
);
  klp_boost_state_t state_r;
  logic [SW-1:0] cnt_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= KLP_ST_STBY;
    end else if (!boostEn) begin
      state_r <= KLP_ST_STBY;
    end else begin
      case (state_r)
        KLP_ST_STBY: state_r <= KLP_ST_SOFT;
        KLP_ST_SOFT: begin
          if (cnt_r == SW'(SOFT_CYC - 1)) begin
            state_r <= KLP_ST_NORM;
          end
        end
        KLP_ST_NORM: state_r <= KLP_ST_NORM;
        default: state_r <= KLP_ST_STBY;
      endcase
    end
  end

  // soft-start duration counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (state_r == KLP_ST_SOFT) begin
      cnt_r <= cnt_r + SW'(1);
    end else begin
      cnt_r <= '0;
    end
  end

  assign boostState = state_r;

  soft_len_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == KLP_ST_SOFT && boostEn && cnt_r == SW'(SOFT_CYC - 1)) |=> state_r == KLP_ST_NORM)
    else $error("soft start did not end after its full length");
  soft_hold_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == KLP_ST_SOFT && boostEn && cnt_r < SW'(SOFT_CYC - 1)) |=> state_r == KLP_ST_SOFT)
    else $error("soft start ended early");
endmodule // klp_soft_start

// *** design/klp_keypad_ctrl.sv ***
// keypad led pwm controller: registers, slot timing and output gating
`timescale 1ns/100ps
`include "klp_params.svh"
module klp_keypad_ctrl #(
  parameter int FRAME_CYC = `KLP_FRAME_CYC,
  parameter int SOFT_CYC = `KLP_SOFT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port behind the serial interface
  input wire klp_pkg::klp_reg_req_t regReq,
  output logic [7:0] regRdData,
  // external pwm input, active high
  input wire logic extPwmIn,
  // keypad sink outputs
  output klp_pkg::klp_sink_t sinkOut,
  output logic keySwitchMode,
  // boost converter control
  output logic boostStandby,
  output logic boostLowCurrent,
  output logic boostNormal
);
  import klp_pkg::*;

  localparam int CW = $clog2(FRAME_CYC + 1);

  logic [7:0] ctrl_r;
  logic [7:0] dim_r;
  logic [7:0] extSel_r;
  logic boostEn_r;
  logic [7:0] rdData_r;
  klp_dim_t actDim_r;
  logic [CW-1:0] end1_r;
  logic [CW-1:0] end2_r;
  logic [CW-1:0] end3_r;
  logic [CW-1:0] ovEnd_r;
  klp_sink_t sink_r;
  klp_sink_t sink_nxt;
  klp_dim_t dimNow;
  klp_boost_state_t boostState;
  logic [CW-1:0] frameCnt;
  logic frameStart;
  logic blank;
  logic [2:0] onBits;
  logic [2:0] wave;
  logic [7:0] rdMux;

  // full-brightness slot length of one output for a balance code
  function automatic int shareLen(input logic [2:0] bal, input int idx);
    int len;
    len = 0;
    case (bal)
      3'h0: len = (idx == 0) ? FRAME_CYC : 0;
      3'h1: len = (idx == 1) ? FRAME_CYC : 0;
      3'h2: len = (idx == 2) ? FRAME_CYC : 0;
      3'h3: len = (idx == 2) ? 0 : FRAME_CYC / 2;
      3'h4: len = (idx == 0) ? 0 : FRAME_CYC / 2;
      3'h5: len = (idx == 1) ? 0 : FRAME_CYC / 2;
      3'h6: len = FRAME_CYC / 3;
      3'h7: len = (idx == 0) ? FRAME_CYC / 2 : FRAME_CYC / 4;
      default: len = 0;
    endcase
    return len;
  endfunction

  // logarithmic brightness: code 1 is 1/64, each step doubles, code 7 is full
  function automatic int scaleLen(input int len, input logic [2:0] bright);
    int res;
    res = 0;
    if (bright != 3'h0) begin
      res = len >> (7 - int'(bright));
    end
    return res;
  endfunction

  // register writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= `KLP_CTRL_RESET;
    end else if (regReq.wrEn && regReq.addr == `KLP_ADDR_CTRL) begin
      ctrl_r <= regReq.wrData & `KLP_CTRL_MASK;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dim_r <= `KLP_DIM_RESET;
    end else if (regReq.wrEn && regReq.addr == `KLP_ADDR_DIM) begin
      dim_r <= regReq.wrData & `KLP_DIM_MASK;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      extSel_r <= `KLP_EXT_RESET;
    end else if (regReq.wrEn && regReq.addr == `KLP_ADDR_EXTPWM) begin
      extSel_r <= regReq.wrData & `KLP_EXT_MASK;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      boostEn_r <= `KLP_BOOST_RESET;
    end else if (regReq.wrEn && regReq.addr == `KLP_ADDR_BOOST) begin
      boostEn_r <= regReq.wrData[`KLP_BOOST_EN];
    end
  end

  // register reads, answered one cycle after the read strobe
  always_comb begin
    rdMux = 8'h00;
    case (regReq.addr)
      `KLP_ADDR_CTRL: rdMux = ctrl_r;
      `KLP_ADDR_DIM: rdMux = dim_r;
      `KLP_ADDR_EXTPWM: rdMux = extSel_r;
      `KLP_ADDR_BOOST: rdMux = {7'h00, boostEn_r};
      `KLP_ADDR_STATUS: rdMux = {5'h00, boostNormal, boostLowCurrent, boostStandby};
      default: rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData_r <= 8'h00;
    end else if (regReq.rdEn) begin
      rdData_r <= rdMux;
    end
  end

  assign regRdData = rdData_r;

  // boost sequencing and frame timing
  klp_soft_start #(
    .SOFT_CYC(SOFT_CYC)
  ) u_soft (
    .clk(clk),
    .rst(rst),
    .boostEn(boostEn_r),
    .boostState(boostState)
  );

  klp_frame_timer #(
    .FRAME_CYC(FRAME_CYC),
    .CW(CW)
  ) u_frame (
    .clk(clk),
    .rst(rst),
    .frameCnt(frameCnt),
    .frameStart(frameStart)
  );

  assign boostStandby = boostState[0];
  assign boostLowCurrent = boostState[1];
  assign boostNormal = boostState[2];
  // blanking starts one cycle ahead of the soft-start state because sinkOut is registered
  assign blank = (boostState == KLP_ST_SOFT) || (boostState == KLP_ST_STBY && boostEn_r);
  assign keySwitchMode = ctrl_r[`KLP_CTRL_MODESW];

  soft_dark_a: assert property (@(posedge clk) disable iff (rst)
    boostLowCurrent |-> sinkOut == '0)
    else $error("led driven while converter in low-current start");
  frame_wrap_a: assert property (@(posedge clk) disable iff (rst)
    frameCnt == CW'(FRAME_CYC - 1) |=> frameStart)
    else $error("frame did not wrap after its full length");

  // dimming settings and slot boundaries latched at each frame start
  assign dimNow = klp_dim_t'(dim_r[6:0]);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      actDim_r <= '0;
    end else if (frameStart) begin
      actDim_r <= dimNow;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      end1_r <= '0;
      end2_r <= '0;
      end3_r <= '0;
      ovEnd_r <= '0;
    end else if (frameStart) begin
      end1_r <= CW'(scaleLen(shareLen(dimNow.balance, 0), dimNow.bright));
      end2_r <= CW'(scaleLen(shareLen(dimNow.balance, 0), dimNow.bright)
        + scaleLen(shareLen(dimNow.balance, 1), dimNow.bright));
      end3_r <= CW'(scaleLen(shareLen(dimNow.balance, 0), dimNow.bright)
        + scaleLen(shareLen(dimNow.balance, 1), dimNow.bright)
        + scaleLen(shareLen(dimNow.balance, 2), dimNow.bright));
      ovEnd_r <= CW'(scaleLen(FRAME_CYC, dimNow.bright));
    end
  end

  // internal waveform per output
  always_comb begin
    if (actDim_r.concurrentSlotsSel) begin
      wave = {3{frameCnt < ovEnd_r}};
    end else begin
      wave[0] = (frameCnt < end1_r);
      wave[1] = (frameCnt >= end1_r) && (frameCnt < end2_r);
      wave[2] = (frameCnt >= end2_r) && (frameCnt < end3_r);
    end
  end

  assign onBits = {ctrl_r[`KLP_CTRL_ON3], ctrl_r[`KLP_CTRL_ON2], ctrl_r[`KLP_CTRL_ON1]};

  // output gating: drive enable, per-output on bit, soft-start blanking, pwm sources
  always_comb begin
    logic [2:0] drv;
    drv = 3'h0;
    for (int i = 0; i < 3; i++) begin
      if (ctrl_r[`KLP_CTRL_INTPWM]) begin
        drv[i] = wave[i] && (!extSel_r[i] || extPwmIn);
      end else begin
        drv[i] = !extSel_r[i] || extPwmIn;
      end
      drv[i] = drv[i] && onBits[i] && ctrl_r[`KLP_CTRL_DRVEN] && !blank;
    end
    sink_nxt = klp_sink_t'(drv);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sink_r <= '0;
    end else begin
      sink_r <= sink_nxt;
    end
  end

  assign sinkOut = sink_r;

  logic pwmPlain;
  assign pwmPlain = ctrl_r[`KLP_CTRL_DRVEN] && ctrl_r[`KLP_CTRL_INTPWM] && extSel_r[2:0] == 3'h0 && !blank;

  boost_stby_a: assert property (@(posedge clk) disable iff (rst)
    !boostEn_r ##1 !boostEn_r |-> boostStandby && !boostLowCurrent && !boostNormal)
    else $error("boost not in standby while disabled");
  boost_start_a: assert property (@(posedge clk) disable iff (rst)
    boostStandby && boostEn_r |=> boostLowCurrent)
    else $error("boost did not enter soft start");
  blank_leds_a: assert property (@(posedge clk) disable iff (rst)
    blank |=> sinkOut == '0)
    else $error("led driven during soft start");
  mode_sel_a: assert property (@(posedge clk) disable iff (rst)
    regReq.wrEn && regReq.addr == `KLP_ADDR_CTRL |=> keySwitchMode == $past(regReq.wrData[`KLP_CTRL_MODESW]))
    else $error("mode select not taken from control write");
  off_disabled_a: assert property (@(posedge clk) disable iff (rst)
    !ctrl_r[`KLP_CTRL_ON2] |=> !sinkOut.sinkOut2)
    else $error("disabled output driven");
  zero_bright_a: assert property (@(posedge clk) disable iff (rst)
    ctrl_r[`KLP_CTRL_INTPWM] && actDim_r.bright == 3'h0 && !frameStart |=> sinkOut == '0)
    else $error("output on at zero brightness");
  slots_disjoint_a: assert property (@(posedge clk) disable iff (rst)
    ctrl_r[`KLP_CTRL_INTPWM] && !actDim_r.concurrentSlotsSel |=> $onehot0(sinkOut))
    else $error("slots overlap in non-overlapping operation");
  overlap_same_a: assert property (@(posedge clk) disable iff (rst)
    pwmPlain && actDim_r.concurrentSlotsSel && onBits == 3'h7 |=>
    sinkOut.sinkOut1 == sinkOut.sinkOut2 && sinkOut.sinkOut2 == sinkOut.sinkOut3)
    else $error("overlapping outputs differ");
  ovl_window_a: assert property (@(posedge clk) disable iff (rst)
    pwmPlain && actDim_r.concurrentSlotsSel && onBits == 3'h7 && frameCnt < ovEnd_r |=>
    sinkOut == 3'h7)
    else $error("overlapping outputs off inside the on-time");
  overlap_off_a: assert property (@(posedge clk) disable iff (rst)
    ctrl_r[`KLP_CTRL_INTPWM] && actDim_r.concurrentSlotsSel && frameCnt >= ovEnd_r |=> sinkOut == '0)
    else $error("overlapping outputs on after the on-time");
  first_slot_a: assert property (@(posedge clk) disable iff (rst)
    pwmPlain && onBits[0] && !actDim_r.concurrentSlotsSel && frameCnt < end1_r |=> sinkOut.sinkOut1)
    else $error("output 1 off inside its slot");
  second_slot_a: assert property (@(posedge clk) disable iff (rst)
    pwmPlain && onBits[1] && !actDim_r.concurrentSlotsSel && frameCnt >= end1_r && frameCnt < end2_r |=>
    sinkOut.sinkOut2)
    else $error("output 2 off inside its slot");
  third_slot_a: assert property (@(posedge clk) disable iff (rst)
    pwmPlain && onBits[2] && !actDim_r.concurrentSlotsSel && frameCnt >= end2_r && frameCnt < end3_r |=>
    sinkOut.sinkOut3)
    else $error("output 3 off inside its slot");
  frame_tail_a: assert property (@(posedge clk) disable iff (rst)
    ctrl_r[`KLP_CTRL_INTPWM] && !actDim_r.concurrentSlotsSel && frameCnt >= end3_r |=> sinkOut == '0)
    else $error("output on after the active slots");
  direct_follow_a: assert property (@(posedge clk) disable iff (rst)
    ctrl_r[`KLP_CTRL_DRVEN] && !ctrl_r[`KLP_CTRL_INTPWM] && extSel_r == 8'h00 && !blank |=>
    sinkOut == klp_sink_t'($past(onBits)))
    else $error("direct mode output does not follow on bits");
  ext_gate_a: assert property (@(posedge clk) disable iff (rst)
    extSel_r[0] && !extPwmIn |=> !sinkOut.sinkOut1)
    else $error("external pwm low did not gate output");
  ext_direct_a: assert property (@(posedge clk) disable iff (rst)
    ctrl_r[`KLP_CTRL_DRVEN] && !ctrl_r[`KLP_CTRL_INTPWM] && extSel_r[0] && onBits[0] && !blank |=>
    sinkOut.sinkOut1 == $past(extPwmIn))
    else $error("selected output does not follow external pwm");
  frame_latch_a: assert property (@(posedge clk) disable iff (rst)
    !frameStart |=> $stable(actDim_r))
    else $error("dimming settings changed inside a frame");

  soft_done_c: cover property (@(posedge clk) disable iff (rst) boostLowCurrent ##1 boostNormal);
  overlap_run_c: cover property (@(posedge clk) disable iff (rst)
    actDim_r.concurrentSlotsSel && sinkOut == 3'h7);
  third_slot_c: cover property (@(posedge clk) disable iff (rst)
    !actDim_r.concurrentSlotsSel && sinkOut.sinkOut3);
  ext_gated_c: cover property (@(posedge clk) disable iff (rst)
    ctrl_r[`KLP_CTRL_INTPWM] && extSel_r[0] && extPwmIn && sinkOut.sinkOut1);
  ext_direct_c: cover property (@(posedge clk) disable iff (rst)
    !ctrl_r[`KLP_CTRL_INTPWM] && extSel_r[0] && sinkOut.sinkOut1);
endmodule // klp_keypad_ctrl

// *** bench/klp_led_strings.sv ***
// three keypad led strings seen as on-time counters per output
`timescale 1ns/100ps
module klp_led_strings
  import klp_pkg::*;
(
  // clock
  input wire logic clk,
  // sink drive from the block and count clear from the bench
  input wire klp_pkg::klp_sink_t sinkOut,
  input wire logic clr,
  // cycles each string was lit since the last clear
  output logic [7:0] onCnt1,
  output logic [7:0] onCnt2,
  output logic [7:0] onCnt3
);
  always_ff @(posedge clk) begin
    if (clr) begin
      onCnt1 <= 8'h00;
      onCnt2 <= 8'h00;
      onCnt3 <= 8'h00;
    end else begin
      onCnt1 <= onCnt1 + 8'(sinkOut.sinkOut1);
      onCnt2 <= onCnt2 + 8'(sinkOut.sinkOut2);
      onCnt3 <= onCnt3 + 8'(sinkOut.sinkOut3);
    end
  end
endmodule // klp_led_strings

// *** bench/keypad_led_pwm_controller_tb.sv ***
// self-checking bench for the keypad led pwm controller
`timescale 1ns/100ps
`include "klp_params.svh"
module keypad_led_pwm_controller_tb;
  import klp_pkg::*;
  localparam int FR = 64;
  logic clk = 1'b0;
  logic rst = 1'b1;
  klp_reg_req_t regReq = '0;
  logic extPwmIn = 1'b0;
  logic clr = 1'b0;
  logic [7:0] regRdData;
  klp_sink_t sinkOut;
  logic keySwitchMode;
  logic boostStandby;
  logic boostLowCurrent;
  logic boostNormal;
  logic [7:0] onCnt1;
  logic [7:0] onCnt2;
  logic [7:0] onCnt3;
  int nMismatch = 0;
  int checked = 0;
  // expected lit cycles per frame at full brightness, by balance code
  int shareTab [8][3] = '{'{64, 0, 0}, '{0, 64, 0}, '{0, 0, 64}, '{32, 32, 0},
    '{0, 32, 32}, '{32, 0, 32}, '{21, 21, 21}, '{32, 16, 16}};

  always #5 clk = ~clk;

  klp_keypad_ctrl #(.FRAME_CYC(FR), .SOFT_CYC(20)) DUT (
    .clk(clk),
    .rst(rst),
    .regReq(regReq),
    .regRdData(regRdData),
    .extPwmIn(extPwmIn),
    .sinkOut(sinkOut),
    .keySwitchMode(keySwitchMode),
    .boostStandby(boostStandby),
    .boostLowCurrent(boostLowCurrent),
    .boostNormal(boostNormal)
  );

  klp_led_strings strings (
    .clk(clk),
    .sinkOut(sinkOut),
    .clr(clr),
    .onCnt1(onCnt1),
    .onCnt2(onCnt2),
    .onCnt3(onCnt3)
  );

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      nMismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // every task starts and ends just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 regReq = {1'b1, 1'b0, a, d};
    @(posedge clk);
    #1 regReq.wrEn = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1 regReq = {1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    #1 regReq.rdEn = 1'b0;
    chk(regRdData, exp);
  endtask

  // wait past a frame start so new dimming settings apply
  task automatic settle();
    repeat (2 * FR + 2) @(posedge clk);
    #1;
  endtask

  task automatic cnt(input int n, input int e1, input int e2, input int e3);
    clr = 1'b1;
    @(posedge clk);
    #1 clr = 1'b0;
    repeat (n) @(posedge clk);
    #1;
    chk(onCnt1, 8'(e1));
    chk(onCnt2, 8'(e2));
    chk(onCnt3, 8'(e3));
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, nMismatch);
    if (nMismatch == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    rd(`KLP_ADDR_CTRL, `KLP_CTRL_RESET);
    chk(8'(keySwitchMode), 8'h01);
    chk(8'(boostStandby), 8'h01);
    rd(`KLP_ADDR_DIM, 8'h00);
    rd(8'h05, 8'h00);
    $display("test reset done");
    wr(`KLP_ADDR_CTRL, 8'h1f);
    chk(8'(keySwitchMode), 8'h00);
    rd(`KLP_ADDR_CTRL, 8'h1f);
    for (int b = 0; b < 8; b++) begin
      wr(`KLP_ADDR_DIM, {4'h0, 3'(b), 1'b0});
      settle();
      cnt(FR, FR >> (7 - b), 0, 0);
    end
    $display("test brightness done");
    for (int s = 0; s < 8; s++) begin
      wr(`KLP_ADDR_DIM, {1'b0, 3'(s), 3'h7, 1'b0});
      rd(`KLP_ADDR_DIM, {1'b0, 3'(s), 3'h7, 1'b0});
      settle();
      cnt(FR, shareTab[s][0], shareTab[s][1], shareTab[s][2]);
    end
    $display("test balance done");
    wr(`KLP_ADDR_DIM, 8'h3d);
    settle();
    cnt(FR, 32, 32, 32);
    wr(`KLP_ADDR_CTRL, 8'h1d);
    wr(`KLP_ADDR_DIM, 8'h6c);
    settle();
    cnt(FR, 10, 0, 10);
    $display("test overlap and half brightness done");
    wr(`KLP_ADDR_CTRL, 8'h15);
    cnt(FR, 64, 0, 64);
    wr(`KLP_ADDR_EXTPWM, 8'h01);
    extPwmIn = 1'b1;
    cnt(FR, 64, 0, 64);
    extPwmIn = 1'b0;
    cnt(FR, 0, 0, 64);
    wr(`KLP_ADDR_CTRL, 8'h1f);
    cnt(FR, 0, 10, 10);
    extPwmIn = 1'b1;
    cnt(FR, 10, 10, 10);
    extPwmIn = 1'b0;
    $display("test direct and external drive done");
    wr(`KLP_ADDR_EXTPWM, 8'h00);
    wr(`KLP_ADDR_CTRL, 8'h1f);
    wr(`KLP_ADDR_DIM, 8'h0e);
    wr(`KLP_ADDR_BOOST, 8'h01);
    repeat (2) @(posedge clk);
    #1;
    chk(8'(boostLowCurrent), 8'h01);
    chk(8'(boostStandby), 8'h00);
    cnt(15, 0, 0, 0);
    for (int i = 0; i < 50 && boostNormal !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk(8'(boostNormal), 8'h01);
    // a timed-out soft start is already counted; go straight to the report
    if (boostNormal === 1'b1) begin
      rd(`KLP_ADDR_STATUS, 8'h04);
      settle();
      cnt(FR, 64, 0, 0);
      wr(`KLP_ADDR_BOOST, 8'h00);
      repeat (2) @(posedge clk);
      #1;
      chk(8'(boostStandby), 8'h01);
      chk(8'(boostNormal), 8'h00);
    end
    $display("test boost sequence done");
    finish_test();
  end
endmodule // keypad_led_pwm_controller_tb
